// ### verilog/slm_top.sv
// safety limit monitor: latched high/low limit with hysteresis, APB registers and safe output
`timescale 1ns/100ps

`include "slm_defines.svh"

module slm_top
    import slm_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // process value from the converter, same clock
    input wire logic [17:0] i_pv,
    input wire logic i_pv_valid,
    // asynchronous inputs from pins
    input wire logic i_pv_error,
    input wire logic i_limit_reset,
    // dedicated limit output stage and interrupt
    output logic o_limit_out,
    output logic o_irq
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // bound a value to [lo, hi]; the lower bound wins if the two cross
    function automatic slm_val_t clamp(input slm_val_t v, input slm_val_t lo, input slm_val_t hi);
        slm_val_t t;
        t = (v > hi) ? hi : v;
        t = (t < lo) ? lo : t;
        return t;
    endfunction

    // sign-extend to 20 bits so that sums of set point and hysteresis cannot wrap
    function automatic logic signed [19:0] ext(input slm_val_t v);
        return {{2{v[17]}}, v};
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    slm_state_s r_ff;
    slm_state_s nxt_r;

    logic wr;
    logic clr_cmd;
    logic [2:0] w1c;
    logic [2:0] ev;
    logic hi_en;
    logic lo_en;
    logic hi_ok;
    logic lo_ok;
    logic rel_req;
    logic signed [19:0] pv20;
    logic signed [19:0] hi20;
    logic signed [19:0] lo20;
    logic signed [19:0] hy20;
    slm_val_t wval;

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb
    begin
        nxt_r = r_ff;
        wr = i_psel & i_penable & r_ff.pready & i_pwrite;
        wval = slm_val_t'(i_pwdata[17:0]);
        clr_cmd = 1'b0;
        w1c = 3'h0;
        ev = 3'h0;

        // two flops on each pin input before anything looks at it
        nxt_r.rst_s1 = i_limit_reset;
        nxt_r.rst_s2 = r_ff.rst_s1;
        nxt_r.rst_d = r_ff.rst_s2;
        nxt_r.err_s1 = i_pv_error;
        nxt_r.err_s2 = r_ff.err_s1;
        if (i_pv_valid)
        begin
            nxt_r.pv = slm_val_t'(i_pv);
        end

        // register writes take effect in the access phase
        if (wr)
        begin
            case (i_paddr)
                `SLM_OFS_CTRL:
                begin
                    // reserved encoding 3 falls back to both sides
                    nxt_r.sides = (i_pwdata[`SLM_CTRL_SIDES_MSB:`SLM_CTRL_SIDES_LSB] == 2'h3) ?
                        SLM_SIDES_BOTH : i_pwdata[`SLM_CTRL_SIDES_MSB:`SLM_CTRL_SIDES_LSB];
                    clr_cmd = i_pwdata[`SLM_CTRL_CLEAR_BIT];
                end
                `SLM_OFS_HYST:
                begin
                    // negative hysteresis would make release easier than trip
                    nxt_r.hyst = clamp(wval, 18'h00000, `SLM_SP_MAX_LIM);
                end
                `SLM_OFS_MIN_SP:
                begin
                    nxt_r.min_sp = clamp(wval, `SLM_SP_MIN_LIM, `SLM_SP_MAX_LIM);
                end
                `SLM_OFS_MAX_SP:
                begin
                    nxt_r.max_sp = clamp(wval, `SLM_SP_MIN_LIM, `SLM_SP_MAX_LIM);
                end
                `SLM_OFS_HIGH_SP:
                begin
                    nxt_r.high_sp = wval;
                end
                `SLM_OFS_LOW_SP:
                begin
                    nxt_r.low_sp = wval;
                end
                `SLM_OFS_IRQ_STAT:
                begin
                    w1c = i_pwdata[2:0];
                end
                `SLM_OFS_IRQ_MASK:
                begin
                    nxt_r.irq_mask = i_pwdata[2:0];
                end
                default:
                begin
                    nxt_r.sides = r_ff.sides;
                end
            endcase
        end

        // set points are re-bounded every cycle so that moving a bound drags them along
        nxt_r.high_sp = clamp(nxt_r.high_sp, nxt_r.min_sp, nxt_r.max_sp);
        nxt_r.low_sp = clamp(nxt_r.low_sp, nxt_r.min_sp, nxt_r.max_sp);
        if (nxt_r.low_sp > nxt_r.min_sp)
        begin
            nxt_r.low_sp = nxt_r.min_sp;
        end

        // limit comparison against the active sides
        hi_en = (r_ff.sides != SLM_SIDES_LOW);
        lo_en = (r_ff.sides != SLM_SIDES_HIGH);
        pv20 = ext(r_ff.pv);
        hi20 = ext(r_ff.high_sp);
        lo20 = ext(r_ff.low_sp);
        hy20 = ext(r_ff.hyst);
        nxt_r.high_cond = hi_en & (pv20 > hi20);
        nxt_r.low_cond = lo_en & (pv20 < lo20);
        hi_ok = ~hi_en | (pv20 <= hi20 - hy20);
        lo_ok = ~lo_en | (pv20 >= lo20 + hy20);

        // release request: rising edge of the reset input or a clear command
        rel_req = (r_ff.rst_s2 & ~r_ff.rst_d) | clr_cmd;

        // latched limit status
        case (r_ff.st)
            SLM_ST_SAFE:
            begin
                if (r_ff.err_s2)
                begin
                    nxt_r.st = SLM_ST_FAIL;
                end
                else if (nxt_r.high_cond | nxt_r.low_cond)
                begin
                    nxt_r.st = SLM_ST_TRIP;
                end
            end
            SLM_ST_TRIP:
            begin
                if (r_ff.err_s2)
                begin
                    nxt_r.st = SLM_ST_FAIL;
                end
                else if (rel_req & hi_ok & lo_ok)
                begin
                    nxt_r.st = SLM_ST_SAFE;
                end
            end
            SLM_ST_FAIL:
            begin
                // a recovered input does not re-arm the output on its own
                if (!r_ff.err_s2)
                begin
                    nxt_r.st = SLM_ST_TRIP;
                end
            end
            default:
            begin
                nxt_r.st = SLM_ST_TRIP;
            end
        endcase

        // sticky events; a new event wins over a write-one-to-clear
        ev[`SLM_IRQ_TRIP_BIT] = (r_ff.st == SLM_ST_SAFE) & (nxt_r.st == SLM_ST_TRIP);
        ev[`SLM_IRQ_FAIL_BIT] = (r_ff.st != SLM_ST_FAIL) & (nxt_r.st == SLM_ST_FAIL);
        ev[`SLM_IRQ_RELEASE_BIT] = (r_ff.st != SLM_ST_SAFE) & (nxt_r.st == SLM_ST_SAFE);
        nxt_r.irq_stat = (r_ff.irq_stat & ~w1c) | ev;
        nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);

        // the safe level goes to one flop, which drives the dedicated output and status bit 0
        nxt_r.safe = (nxt_r.st == SLM_ST_SAFE);

        // apb: answer registered in the setup phase, ready high in the first access cycle
        nxt_r.pready = i_psel & ~i_penable;
        nxt_r.pslverr = 1'b0;
        nxt_r.prdata = 32'h00000000;
        if (i_psel & ~i_penable)
        begin
            case (i_paddr)
                `SLM_OFS_CTRL:
                begin
                    nxt_r.prdata = {30'h00000000, r_ff.sides};
                end
                `SLM_OFS_HYST:
                begin
                    nxt_r.prdata = {{14{r_ff.hyst[17]}}, r_ff.hyst};
                end
                `SLM_OFS_MIN_SP:
                begin
                    nxt_r.prdata = {{14{r_ff.min_sp[17]}}, r_ff.min_sp};
                end
                `SLM_OFS_MAX_SP:
                begin
                    nxt_r.prdata = {{14{r_ff.max_sp[17]}}, r_ff.max_sp};
                end
                `SLM_OFS_HIGH_SP:
                begin
                    nxt_r.prdata = {{14{r_ff.high_sp[17]}}, r_ff.high_sp};
                end
                `SLM_OFS_LOW_SP:
                begin
                    nxt_r.prdata = {{14{r_ff.low_sp[17]}}, r_ff.low_sp};
                end
                `SLM_OFS_STATUS:
                begin
                    nxt_r.prdata = {27'h0000000, (r_ff.st == SLM_ST_FAIL), r_ff.low_cond,
                        r_ff.high_cond, (r_ff.st != SLM_ST_SAFE), r_ff.safe};
                end
                `SLM_OFS_IRQ_STAT:
                begin
                    nxt_r.prdata = {29'h00000000, r_ff.irq_stat};
                end
                `SLM_OFS_IRQ_MASK:
                begin
                    nxt_r.prdata = {29'h00000000, r_ff.irq_mask};
                end
                `SLM_OFS_PV:
                begin
                    nxt_r.prdata = {{14{r_ff.pv[17]}}, r_ff.pv};
                end
                default:
                begin
                    nxt_r.pslverr = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register; powers up tripped so the energy source starts disabled
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r_ff.sides <= `SLM_RST_SIDES;
            r_ff.hyst <= `SLM_RST_HYST;
            r_ff.min_sp <= `SLM_RST_MIN_SP;
            r_ff.max_sp <= `SLM_RST_MAX_SP;
            r_ff.high_sp <= `SLM_RST_HIGH_SP;
            r_ff.low_sp <= `SLM_RST_LOW_SP;
            r_ff.pv <= 18'h00000;
            r_ff.st <= SLM_ST_TRIP;
            r_ff.high_cond <= 1'b0;
            r_ff.low_cond <= 1'b0;
            r_ff.irq_stat <= 3'h0;
            r_ff.irq_mask <= `SLM_RST_IRQ_MASK;
            r_ff.rst_s1 <= 1'b0;
            r_ff.rst_s2 <= 1'b0;
            r_ff.rst_d <= 1'b0;
            r_ff.err_s1 <= 1'b0;
            r_ff.err_s2 <= 1'b0;
            r_ff.prdata <= 32'h00000000;
            r_ff.pready <= 1'b0;
            r_ff.pslverr <= 1'b0;
            r_ff.safe <= 1'b0;
            r_ff.irq <= 1'b0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, each straight from a flop
    // ------------------------------------------------------------------------
    assign o_prdata = r_ff.prdata;
    assign o_pready = r_ff.pready;
    assign o_pslverr = r_ff.pslverr;
    assign o_limit_out = r_ff.safe;
    assign o_irq = r_ff.irq;

endmodule

// ### verilog/slm_defines.svh
// register offsets, field positions, reset values and limits of the safety limit monitor
`ifndef SLM_DEFINES_SVH
`define SLM_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SLM_OFS_CTRL 8'h00
`define SLM_OFS_HYST 8'h04
`define SLM_OFS_MIN_SP 8'h08
`define SLM_OFS_MAX_SP 8'h0C
`define SLM_OFS_HIGH_SP 8'h10
`define SLM_OFS_LOW_SP 8'h14
`define SLM_OFS_STATUS 8'h18
`define SLM_OFS_IRQ_STAT 8'h1C
`define SLM_OFS_IRQ_MASK 8'h20
`define SLM_OFS_PV 8'h24

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SLM_CTRL_SIDES_LSB 0
`define SLM_CTRL_SIDES_MSB 1
`define SLM_CTRL_CLEAR_BIT 2
`define SLM_STAT_SAFE_BIT 0
`define SLM_STAT_LATCH_BIT 1
`define SLM_STAT_HIGH_BIT 2
`define SLM_STAT_LOW_BIT 3
`define SLM_STAT_FAIL_BIT 4
`define SLM_IRQ_TRIP_BIT 0
`define SLM_IRQ_FAIL_BIT 1
`define SLM_IRQ_RELEASE_BIT 2

// ----------------------------------------------------------------------------
// value range and reset values (18-bit two's complement)
// ----------------------------------------------------------------------------
`define SLM_SP_MAX_LIM 18'h1869F
`define SLM_SP_MIN_LIM 18'h27961
`define SLM_RST_SIDES 2'h0
`define SLM_RST_HYST 18'h00000
`define SLM_RST_MIN_SP 18'h27961
`define SLM_RST_MAX_SP 18'h1869F
`define SLM_RST_HIGH_SP 18'h1869F
`define SLM_RST_LOW_SP 18'h27961
`define SLM_RST_IRQ_MASK 3'h0

`endif

// ### verilog/slm_pkg.sv
// types shared by the safety limit monitor
package slm_pkg;

    // ------------------------------------------------------------------------
    // value and mode types
    // ------------------------------------------------------------------------
    typedef logic signed [17:0] slm_val_t;

    typedef enum logic [1:0]
    {
        SLM_SIDES_BOTH = 2'h0,
        SLM_SIDES_HIGH = 2'h1,
        SLM_SIDES_LOW = 2'h2
    } slm_sides_e;

    // limit status, one-hot
    typedef enum logic [2:0]
    {
        SLM_ST_SAFE = 3'h1,
        SLM_ST_TRIP = 3'h2,
        SLM_ST_FAIL = 3'h4
    } slm_state_e;

    // ------------------------------------------------------------------------
    // whole state of the monitor
    // ------------------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] sides;
        slm_val_t hyst;
        slm_val_t min_sp;
        slm_val_t max_sp;
        slm_val_t high_sp;
        slm_val_t low_sp;
        slm_val_t pv;
        slm_state_e st;
        logic high_cond;
        logic low_cond;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic rst_s1;
        logic rst_s2;
        logic rst_d;
        logic err_s1;
        logic err_s2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic safe;
        logic irq;
    } slm_state_s;

endpackage

// ### bench/slm_top_assertions.sv
// port-level assertion checker of the safety limit monitor, bound to its top module
`timescale 1ns/100ps
module slm_top_assertions
(
    // clock, reset and apb
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // limit path
    input wire logic [17:0] i_pv,
    input wire logic i_pv_valid,
    input wire logic i_pv_error,
    input wire logic i_limit_reset,
    input wire logic o_limit_out,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // access edges that may move the latch; past values need plain signals
    logic clear_acc;
    logic wr_acc;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign clear_acc = wr_acc && (i_paddr == 8'h00) && i_pwdata[2];

    // the steps of an apb setup and of a held sensor error
    sequence setup_phase;
        i_psel && !i_penable;
    endsequence
    sequence err_held;
        i_pv_error [*3];
    endsequence

    a_ready_after_setup: assert property (setup_phase |=> o_pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
    a_unmapped_error: assert property (setup_phase and i_paddr > 8'h24 |=> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (setup_phase and i_paddr <= 8'h24 && i_paddr[1:0] == 2'h0 |=> !o_pslverr)
        else $error("mapped access refused");
    a_slverr_with_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    a_error_forces_off: assert property (err_held |=> !o_limit_out) else $error("output on during error");
    a_release_cause: assert property ($rose(o_limit_out) |-> $past(clear_acc) || $past(i_limit_reset, 3))
        else $error("output rose without clear or reset input");
    a_trip_cause: assert property ($fell(o_limit_out) |-> $past(i_pv_valid) || $past(i_pv_valid, 2)
        || $past(i_pv_error, 3) || $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3))
        else $error("output fell without a cause");
    a_irq_rise_cause: assert property ($rose(o_irq) |-> $past(wr_acc) || $changed(o_limit_out)
        || $past(i_pv_error, 3)) else $error("interrupt rose without an event");
endmodule

bind slm_top slm_top_assertions i_slm_top_assertions (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pv(i_pv), .i_pv_valid(i_pv_valid), .i_pv_error(i_pv_error),
    .i_limit_reset(i_limit_reset), .o_limit_out(o_limit_out), .o_irq(o_irq));

// ### bench/slm_sensor.sv
// behavioural model of the sensor, the reset source and the energy enable stage
`timescale 1ns/100ps
module slm_sensor
(
    // clock and limit level from the monitor
    input wire logic i_clock,
    input wire logic i_limit_out,
    // converter and pins towards the monitor
    output logic [17:0] o_pv,
    output logic o_pv_valid,
    output logic o_pv_error,
    output logic o_limit_reset,
    // energy source state seen by the load
    output logic o_energy_on
);
    // idle levels at time zero
    initial
    begin
        o_pv = 18'h0;
        o_pv_valid = 1'b0;
        o_pv_error = 1'b0;
        o_limit_reset = 1'b0;
    end

    // the load follows the limit level with nothing in between
    assign o_energy_on = i_limit_out;

    // one converter sample; the bus word flips after so stale data never looks good
    task automatic put_pv(input logic [17:0] v);
        o_pv <= v;
        o_pv_valid <= 1'b1;
        @(posedge i_clock);
        o_pv_valid <= 1'b0;
        o_pv <= ~v;
        @(posedge i_clock);
    endtask

    // sensor fault pin level
    task automatic set_err(input logic e);
        o_pv_error <= e;
        @(posedge i_clock);
    endtask

    // a plain digital point, held long enough for the pin synchroniser
    task automatic push_reset();
        o_limit_reset <= 1'b1;
        repeat (6) @(posedge i_clock);
        o_limit_reset <= 1'b0;
        repeat (6) @(posedge i_clock);
    endtask
endmodule

// ### bench/tb_top.sv
// self-checking testbench of the safety limit monitor
`timescale 1ns/100ps
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pv_valid, pv_error, lim_rst;
    logic pready, pslverr, last_err, out, irq, energy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [17:0] pv;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    slm_top i_slm_top (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_pv(pv), .i_pv_valid(pv_valid), .i_pv_error(pv_error), .i_limit_reset(lim_rst),
        .o_limit_out(out), .o_irq(irq));
    slm_sensor i_slm_sensor (.i_clock(clk), .i_limit_out(out), .o_pv(pv), .o_pv_valid(pv_valid),
        .o_pv_error(pv_error), .o_limit_reset(lim_rst), .o_energy_on(energy));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer; waits for ready, then an idle edge so the next setup never collides
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    // sides select with the clear command
    task automatic ctl(input logic [1:0] s);
        wr(8'h00, {29'h0, 1'b1, s});
    endtask
    task automatic expect_out(input logic e);
        cyc(3);
        chk({31'h0, out}, {31'h0, e});
    endtask
    task automatic pv_clear_expect(input logic [17:0] v, input logic e);
        i_slm_sensor.put_pv(v);
        ctl(2'h0);
        expect_out(e);
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_power();
        expect_out(1'b0);
        rd(8'h0C, 32'h0001869F);
        rd(8'h08, 32'hFFFE7961);
        rd(8'h30, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        $display("test power done");
    endtask
    task automatic t_bounds();
        wr(8'h0C, 32'h000186A0);
        rd(8'h0C, 32'h0001869F);
        wr(8'h0C, 32'h000001F4);
        wr(8'h10, 32'h000003E8);
        rd(8'h10, 32'h000001F4);
        wr(8'h08, 32'hFFFFFFCE);
        wr(8'h14, 32'h00000000);
        rd(8'h14, 32'hFFFFFFCE);
        wr(8'h10, 32'hFFFFFF00);
        rd(8'h10, 32'hFFFFFFCE);
        wr(8'h10, 32'h00000064);
        wr(8'h04, 32'h0000000A);
        $display("test bounds done");
    endtask
    // high 100, low -50, hysteresis 10
    task automatic t_limits();
        pv_clear_expect(18'h0, 1'b1);
        wr(8'h20, 32'h1);
        i_slm_sensor.put_pv(18'd100);
        expect_out(1'b1);
        i_slm_sensor.put_pv(18'd101);
        expect_out(1'b0);
        rd(8'h24, 32'h00000065);
        chk({31'h0, irq}, 32'h1);
        wr(8'h1C, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        pv_clear_expect(18'd91, 1'b0);
        pv_clear_expect(18'd90, 1'b1);
        i_slm_sensor.put_pv(18'h3FFCD);
        expect_out(1'b0);
        pv_clear_expect(18'h3FFD7, 1'b0);
        pv_clear_expect(18'h3FFD8, 1'b1);
        $display("test limits done");
    endtask
    task automatic t_sides();
        logic [1:0] sd [6];
        logic [17:0] val [6];
        logic ex [6];
        sd = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        val = '{18'd200, 18'h3FFC4, 18'h3FFC4, 18'd200, 18'd200, 18'h3FFC4};
        ex = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        foreach (sd[i])
        begin
            i_slm_sensor.put_pv(18'h0);
            ctl(sd[i]);
            i_slm_sensor.put_pv(val[i]);
            expect_out(ex[i]);
        end
        ctl(2'h0);
        $display("test sides done");
    endtask
    task automatic t_reset_pin();
        wr(8'h20, 32'h0);
        i_slm_sensor.put_pv(18'd200);
        expect_out(1'b0);
        chk({31'h0, irq}, 32'h0);
        i_slm_sensor.push_reset();
        expect_out(1'b0);
        i_slm_sensor.put_pv(18'h0);
        i_slm_sensor.push_reset();
        expect_out(1'b1);
        chk({31'h0, energy}, 32'h1);
        $display("test reset pin done");
    endtask
    task automatic t_error();
        i_slm_sensor.set_err(1'b1);
        expect_out(1'b0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, rdata[4]}, 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, rdata[1]}, 32'h1);
        i_slm_sensor.set_err(1'b0);
        expect_out(1'b0);
        pv_clear_expect(18'h0, 1'b1);
        $display("test error done");
    endtask

    // verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // reset for ten cycles, then the scenarios in order
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(10);
        rst_n <= 1'b1;
        cyc(1);
        t_power();
        t_bounds();
        t_limits();
        t_sides();
        t_reset_pin();
        t_error();
        tally_and_finish();
    end
endmodule
